// ### hdl/ssr_top.sv
// strap status register: strap capture, two control bits, register port
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "ssr_params.svh"

module ssr_top
    import ssr_pkg::*;
(
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    // strap pins, bits 10..2 of the register
    input  wire logic [10:2]              strap_pins,
    // register port
    input  wire logic [`SSR_ADDR_W-1:0]   reg_addr,
    input  wire logic [`SSR_DATA_W-1:0]   reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [`SSR_DATA_W-1:0]   reg_rdata,
    // frame sync delay request from the frame sync control
    input  wire logic                     internal_frame_sync_delay,
    output logic                          frame_sync_delay_active,
    // oscillator sync method
    output logic                          tuned_crystal_oscillator_fast,
    // pcm clock group in (undelayed) and out
    input  wire logic                     pcm_frame_sync_in,
    input  wire logic                     pcm_bit_clock_in,
    input  wire logic                     data_bit_clock_in,
    input  wire logic                     frame_sync_clock_in,
    input  wire logic                     alternate_data_clock_in,
    output logic                          pcm_frame_sync,
    output logic                          pcm_bit_clock,
    output logic                          data_bit_clock,
    output logic                          frame_sync_clock,
    output logic                          alternate_data_clock
);

    ////////////////////////////////////////////////////////////////////
    // state

    ssr_state_t             state;
    ssr_state_t             next_state;
    logic [10:2]            strap_q;
    logic [10:2]            next_strap_q;
    logic                   fast_sync;
    logic                   next_fast_sync;
    logic                   no_delay;
    logic                   next_no_delay;
    logic [`SSR_DATA_W-1:0] status_word;
    logic [`SSR_DATA_W-1:0] next_rdata;
    logic                   hit;
    logic [4:0]             clk_group;
    logic [4:0]             clk_group_out;

    assign hit = (reg_addr == `SSR_OFF_CONFIG_PIN_STATUS);

    ////////////////////////////////////////////////////////////////////
    // strap capture: sampled every cycle while rst is high

    always_comb
    begin
        next_state  = state;
        next_strap_q = strap_q;
        case (state)
            SSR_SAMPLING:
                next_state = SSR_HOLDING;
            SSR_HOLDING:
                next_state = SSR_HOLDING;
            default:
                next_state = SSR_SAMPLING;
        endcase
        // pins are latched only under reset, never by software
        if (rst)
        begin
            next_strap_q = strap_pins;
            next_state   = SSR_SAMPLING;
        end
    end

    // synchronous reset lets the pins be captured by the clock itself
    always_ff @(posedge ref_clk)
    begin
        state   <= next_state;
        strap_q <= next_strap_q;
    end

    ////////////////////////////////////////////////////////////////////
    // writable control bits

    always_comb
    begin
        next_fast_sync = fast_sync;
        next_no_delay  = no_delay;
        if (reg_wr && hit)
        begin
            next_fast_sync = reg_wdata[`SSR_BIT_FAST_SYNC];
            next_no_delay  = reg_wdata[`SSR_BIT_NO_DELAY];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            fast_sync <= `SSR_RST_FAST_SYNC;
            no_delay  <= `SSR_RST_NO_DELAY;
        end
        else
        begin
            fast_sync <= next_fast_sync;
            no_delay  <= next_no_delay;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path

    always_comb
    begin
        status_word = {`SSR_DATA_W{1'b0}};
        status_word[`SSR_BIT_PCM_MASTER] = strap_q[10];
        status_word[`SSR_BIT_TEST_HI:`SSR_BIT_TEST_LO]
            = strap_q[9:7];
        status_word[`SSR_BIT_EMU_BOOT]   = strap_q[6];
        status_word[`SSR_BIT_PLL_BYPASS] = strap_q[5];
        status_word[`SSR_BIT_DSP_PLL_PD] = strap_q[4];
        status_word[`SSR_BIT_BOOT]       = strap_q[3];
        status_word[`SSR_BIT_RSTCNT_BYP] = strap_q[2];
        status_word[`SSR_BIT_FAST_SYNC]  = fast_sync;
        status_word[`SSR_BIT_NO_DELAY]   = no_delay;
        next_rdata = 16'h0000;
        // unmapped reads return zero
        if (reg_rd && hit)
            next_rdata = status_word;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////
    // effects of the control bits

    assign tuned_crystal_oscillator_fast = fast_sync;
    // option ignored unless delay is switched off
    assign frame_sync_delay_active =
        internal_frame_sync_delay & no_delay;

    assign clk_group = {alternate_data_clock_in, frame_sync_clock_in,
                        data_bit_clock_in, pcm_bit_clock_in,
                        pcm_frame_sync_in};

    // delay is one clock period: coarse, but the only one available
    ssr_clk_delay u_delay
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .bypass  (no_delay),
        .clk_in  (clk_group),
        .clk_out (clk_group_out)
    );

    assign pcm_frame_sync       = clk_group_out[0];
    assign pcm_bit_clock        = clk_group_out[1];
    assign data_bit_clock       = clk_group_out[2];
    assign frame_sync_clock     = clk_group_out[3];
    assign alternate_data_clock = clk_group_out[4];

endmodule

// ### hdl/ssr_params.svh
// offsets, field positions, reset values and timing counts for the strap register
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

`define SSR_ADDR_W          16
`define SSR_DATA_W          16
`define SSR_STRAP_W         11
`define SSR_OFF_CONFIG_PIN_STATUS 16'hD08F
`define SSR_BIT_PCM_MASTER  10
`define SSR_BIT_TEST_HI     9
`define SSR_BIT_TEST_LO     7
`define SSR_BIT_EMU_BOOT    6
`define SSR_BIT_PLL_BYPASS  5
`define SSR_BIT_DSP_PLL_PD  4
`define SSR_BIT_BOOT        3
`define SSR_BIT_RSTCNT_BYP  2
`define SSR_BIT_FAST_SYNC   1
`define SSR_BIT_NO_DELAY    0
`define SSR_RST_FAST_SYNC   1'h1
`define SSR_RST_NO_DELAY    1'h0
`define SSR_UNUSED_W        5
`define SSR_CLK_DELAY_NS    40
`define SSR_CLK_PERIOD_NS   40
`define SSR_DELAY_CYCLES    ((`SSR_CLK_DELAY_NS + `SSR_CLK_PERIOD_NS - 1) / `SSR_CLK_PERIOD_NS)

`endif

// ### hdl/ssr_pkg.sv
// types shared by the strap status register block
package ssr_pkg;
    typedef enum logic [1:0]
    {
        SSR_SAMPLING = 2'b01,
        SSR_HOLDING  = 2'b10
    } ssr_state_t;
endpackage

// ### hdl/ssr_clk_delay.sv
// optional one-cycle retiming of the pcm clock group outputs
`timescale 1ns/1ps
`include "ssr_params.svh"

module ssr_clk_delay
    import ssr_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // control
    input  wire logic        bypass,
    // clocks in
    input  wire logic [4:0]  clk_in,
    // clocks out
    output logic      [4:0]  clk_out
);

    logic [4:0] dly_q;
    logic [4:0] next_dly_q;

    always_comb
    begin
        next_dly_q = clk_in;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            dly_q <= 5'h00;
        else
            dly_q <= next_dly_q;
    end

    // bypass shows the raw clocks, else the retimed copy
    assign clk_out = bypass ? clk_in : dly_q;

endmodule

// ### testbench/ssr_chk.sv
// port assertions for the strap status register
`timescale 1ns/1ps
`include "ssr_params.svh"

module ssr_chk
(
    // clock, reset, straps and register port
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [10:2] strap_pins,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_rdata,
    // controls and one member of the clock group
    input  wire logic        internal_frame_sync_delay,
    input  wire logic        frame_sync_delay_active,
    input  wire logic        tuned_crystal_oscillator_fast,
    input  wire logic        pcm_frame_sync_in,
    input  wire logic        pcm_frame_sync
);
    logic [10:2] held;
    logic [1:0]  ctl;
    logic        sel;
    logic        rq;
    assign sel = reg_addr == `SSR_OFF_CONFIG_PIN_STATUS;
    assign rq  = reg_rd & sel;
    // reference copy of the straps and of the two writable bits
    always_ff @(posedge ref_clk)
        held <= rst ? strap_pins : held;
    always_ff @(posedge ref_clk)
        ctl <= rst ? 2'h2 : (reg_wr & sel) ? reg_wdata[1:0] : ctl;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////
    zero_hi_a: assert property (reg_rdata[15:11] == 5'h0)
        else $error("high bits set");
    rd_idle_a: assert property (!$past(rq) |-> !reg_rdata)
        else $error("read data outside its cycle");
    strap_read_a: assert property (rq |=> reg_rdata[10:2] == held)
        else $error("strap bits wrong");
    ctl_rd_a: assert property (rq |=> reg_rdata[1:0] == $past(ctl))
        else $error("control bits wrong");
    sync_method_a: assert property (
        tuned_crystal_oscillator_fast == ctl[1])
        else $error("sync method wrong");
    delay_gate_a: assert property (
        frame_sync_delay_active == (internal_frame_sync_delay & ctl[0]))
        else $error("frame sync delay gate wrong");
    clk_bypass_a: assert property (
        ctl[0] |-> pcm_frame_sync == pcm_frame_sync_in)
        else $error("bypassed clock wrong");
    clk_delay_a: assert property (
        !ctl[0] && !$past(ctl[0]) && !$past(rst)
        |-> pcm_frame_sync == $past(pcm_frame_sync_in))
        else $error("delayed clock wrong");
    rst_val_a: assert property (
        $fell(rst) |-> tuned_crystal_oscillator_fast & !frame_sync_delay_active)
        else $error("reset value wrong");
    cover property (rq && ctl == 2'h3);
    cover property (ctl[0] && internal_frame_sync_delay);
    cover property ($fell(rst));
endmodule

bind ssr_top ssr_chk u_chk (.*);

// ### testbench/test_strap_status_register.sv
// self-checking bench for the strap status register
`timescale 1ns/1ps
`include "ssr_params.svh"

module test_strap_status_register;
    localparam logic [15:0] OFF = `SSR_OFF_CONFIG_PIN_STATUS;
    logic        ref_clk = 1'h0;
    logic        rst     = 1'h1;
    logic [10:2] straps  = 9'h155;
    logic [15:0] addr    = 16'h0;
    logic [15:0] wdata   = 16'h0;
    logic        wr      = 1'h0;
    logic        rd      = 1'h0;
    logic        ifsd    = 1'h1;
    logic [4:0]  pat     = 5'h0;
    logic [4:0]  cko;
    logic [15:0] rdata;
    logic        fsd;
    logic        fast;
    int          n_fail  = 0;
    int          num_checks = 0;
    logic [15:0] row_w [4] = '{16'hFFFC, 16'hFFFD, 16'hFFFE, 16'h0003};
    logic [1:0]  row_q [4] = '{2'h0, 2'h1, 2'h2, 2'h3};

    ssr_top u_dut (.ref_clk(ref_clk), .rst(rst), .strap_pins(straps),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .internal_frame_sync_delay(ifsd),
        .frame_sync_delay_active(fsd), .tuned_crystal_oscillator_fast(fast),
        .pcm_frame_sync_in(pat[4]), .pcm_bit_clock_in(pat[3]),
        .data_bit_clock_in(pat[2]), .frame_sync_clock_in(pat[1]),
        .alternate_data_clock_in(pat[0]), .pcm_frame_sync(cko[4]),
        .pcm_bit_clock(cko[3]), .data_bit_clock(cko[2]),
        .frame_sync_clock(cko[1]), .alternate_data_clock(cko[0]));

    always #20 ref_clk = ~ref_clk;
    // clock group inputs count up as one pattern every cycle, so a missing delay shows
    always @(posedge ref_clk) pat <= pat + 5'h1;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge ref_clk);
        wr <= 1'h0;
    endtask
    // data stands one cycle only, so it is taken just after the edge
    task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge ref_clk);
        rd <= 1'h0;
        #1 chk(rdata, exp);
    endtask
    task automatic close_out;
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        #20000;
        n_fail++;
        close_out;
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst    <= 1'h0;
        straps <= 9'h0AA;
        rd_reg(OFF, {5'h0, 9'h155, 2'h2});
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(OFF, row_w[i]);
            rd_reg(OFF, {5'h0, 9'h155, row_q[i]});
            @(negedge ref_clk);
            chk({14'h0, fast, fsd}, {14'h0, row_q[i]});
            chk({11'h0, cko}, {11'h0, pat - {4'h0, ~row_q[i][0]}});
        end
        @(posedge ref_clk);
        ifsd <= 1'h0;
        @(negedge ref_clk);
        chk({15'h0, fsd}, 16'h0);
        rd_reg(16'hD08E, 16'h0);
        wr_reg(16'hD090, 16'h0);
        rd_reg(OFF, {5'h0, 9'h155, 2'h3});
        @(posedge ref_clk);
        rst <= 1'h1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        rd_reg(OFF, {5'h0, 9'h0AA, 2'h2});
        close_out;
    end
endmodule
